// ==== common/otgsz_defines.svh ====
// Purpose: Offsets, field positions, reset values and sizes of the role and sizing bank
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef OTGSZ_DEFINES_SVH
`define OTGSZ_DEFINES_SVH

// Register byte offsets
`define OTGSZ_OFF_ROLE 4'h0
`define OTGSZ_OFF_EPIDX 4'h4
`define OTGSZ_OFF_TXSZ 4'h8
`define OTGSZ_OFF_RXSZ 4'hC

// Role control fields
`define OTGSZ_SESSION_BIT 0
`define OTGSZ_SWAP_BIT 1
`define OTGSZ_HOST_BIT 2
`define OTGSZ_VBUS_LO 3
`define OTGSZ_VBUS_HI 4

// Size register fields
`define OTGSZ_DPB_BIT 4
`define OTGSZ_EXP_HI 3
`define OTGSZ_EXP_LO 0
`define OTGSZ_SZ_W 5

// VBus level codes
`define OTGSZ_VBUS_BELOW_SE 2'h0
`define OTGSZ_VBUS_ABOVE_SE 2'h1
`define OTGSZ_VBUS_ABOVE_AV 2'h2
`define OTGSZ_VBUS_ABOVE_VV 2'h3

// Reset values
`define OTGSZ_ROLE_RST 1'h0
`define OTGSZ_SZ_RST 5'h00
`define OTGSZ_EPIDX_RST 4'h0

// Endpoints and sizing
`define OTGSZ_NUM_EP 16
`define OTGSZ_EP_W 4
`define OTGSZ_ENTRIES 32
`define OTGSZ_ENT_W 5
`define OTGSZ_BYTES_W 20
`define OTGSZ_BASE_SHIFT 5'h03
`define OTGSZ_DIR_TX 1'h0
`define OTGSZ_DIR_RX 1'h1

`endif

// ==== common/otgsz_pkg.sv ====
// Purpose: Types of the role and sizing bank
// Assumes: otgsz_defines.svh holds every number except the state codes and the bus-side widths
// Notes: State structs, one per module
`include "otgsz_defines.svh"

package otgsz_pkg;

	typedef enum logic [2:0] {
		OTGSZ_S_IDLE = 3'b001,
		OTGSZ_S_WAIT = 3'b010,
		OTGSZ_S_ACK = 3'b100
	} otgsz_bus_st_t;

	typedef struct packed {
		logic [`OTGSZ_ENTRIES-1:0][`OTGSZ_SZ_W-1:0] mem;
		logic [`OTGSZ_SZ_W-1:0] rda;
		logic [`OTGSZ_SZ_W-1:0] rdb;
	} otgsz_mem_t;

	typedef struct packed {
		logic [1:0] code;
	} otgsz_vbus_t;

	typedef struct packed {
		otgsz_bus_st_t st;
		logic [3:0] addr_q;
		logic wr_q;
		logic [7:0] wdata_q;
		logic be0_q;
		logic [31:0] readdata;
		logic waitreq;
		logic session;
		logic swap_req;
		logic host_flag;
		logic suspend_d;
		logic hnp_start;
		logic disconnect;
		logic [`OTGSZ_EP_W-1:0] ep_index;
		logic chk_v;
		logic [`OTGSZ_BYTES_W-1:0] chk_len;
		logic pkt_done;
		logic too_big;
		logic dbl;
		logic [`OTGSZ_BYTES_W-1:0] fifo_bytes;
		logic [`OTGSZ_BYTES_W-1:0] max_pkt;
	} otgsz_top_t;

endpackage : otgsz_pkg

// ==== hdl/otgsz_szmem.sv ====
// Purpose: Holds the size register of every endpoint and direction
// Assumes: Entry index is direction then endpoint
// Notes: Read during write returns the old entry; both reads registered
`timescale 1ns/1ps
`include "otgsz_defines.svh"

module otgsz_szmem (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bus port
	input wire logic [`OTGSZ_ENT_W-1:0] a_addr_i,
	input wire logic a_we_i,
	input wire logic [`OTGSZ_SZ_W-1:0] a_wdata_i,
	output logic [`OTGSZ_SZ_W-1:0] a_rdata_o,
	// Lookup port
	input wire logic [`OTGSZ_ENT_W-1:0] b_addr_i,
	output logic [`OTGSZ_SZ_W-1:0] b_rdata_o
);

	otgsz_pkg::otgsz_mem_t s_r;
	otgsz_pkg::otgsz_mem_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < `OTGSZ_ENTRIES; i++) begin
			if (a_we_i && (a_addr_i == `OTGSZ_ENT_W'(i))) begin
				s_nxt.mem[i] = a_wdata_i;
			end
		end
		s_nxt.rda = s_r.mem[a_addr_i];
		s_nxt.rdb = s_r.mem[b_addr_i];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign a_rdata_o = s_r.rda;
	assign b_rdata_o = s_r.rdb;

endmodule : otgsz_szmem

// ==== hdl/otgsz_top.sv ====
// Purpose: OTG role and session control with per-endpoint FIFO sizing registers
// Assumes: All inputs synchronous to CLK_I; Avalon-MM slave with waitrequest
// Notes: Every access answers in a fixed three cycles
`timescale 1ns/1ps
`include "otgsz_defines.svh"

module otgsz_top (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Avalon-MM slave
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// VBus comparators
	input wire logic ABOVE_SESS_END_I,
	input wire logic ABOVE_AVALID_I,
	input wire logic ABOVE_VBUSVALID_I,
	// Link state
	input wire logic B_DEVICE_I,
	input wire logic HOST_ROLE_I,
	input wire logic SUSPEND_I,
	input wire logic HNP_DONE_I,
	input wire logic SESSION_START_I,
	input wire logic SESSION_END_I,
	// Role outputs
	output logic SESSION_O,
	output logic ROLE_SWAP_REQUEST_O,
	output logic HNP_START_O,
	output logic DISCONNECT_O,
	// Packet size check
	input wire logic PKT_CHK_I,
	input wire logic PKT_DIR_I,
	input wire logic [`OTGSZ_EP_W-1:0] PKT_EP_I,
	input wire logic [`OTGSZ_BYTES_W-1:0] PKT_LEN_I,
	output logic PKT_DONE_O,
	output logic PKT_TOO_BIG_O,
	output logic PKT_DOUBLE_O,
	output logic [`OTGSZ_BYTES_W-1:0] PKT_MAX_BYTES_O,
	output logic [`OTGSZ_BYTES_W-1:0] PKT_FIFO_BYTES_O
);

	otgsz_pkg::otgsz_top_t s_r;
	otgsz_pkg::otgsz_top_t s_nxt;

	logic [1:0] vbus_code;
	logic [`OTGSZ_ENT_W-1:0] mem_a_addr;
	logic mem_a_we;
	logic [`OTGSZ_SZ_W-1:0] mem_a_wdata;
	logic [`OTGSZ_SZ_W-1:0] mem_a_rdata;
	logic [`OTGSZ_ENT_W-1:0] mem_b_addr;
	logic [`OTGSZ_SZ_W-1:0] mem_b_rdata;
	logic [3:0] live_addr;
	logic [3:0] sel_addr;
	logic sel_rx;
	logic do_write;
	logic wr_role;
	logic [4:0] max_shift;
	logic [4:0] fifo_shift;

	otgsz_vbus_enc u_vbus (
		.clk_i(CLK_I),
		.rst_n_i(RESETN_I),
		.above_sess_end_i(ABOVE_SESS_END_I),
		.above_avalid_i(ABOVE_AVALID_I),
		.above_vbusvalid_i(ABOVE_VBUSVALID_I),
		.code_o(vbus_code)
	);

	otgsz_szmem u_szmem (
		.clk_i(CLK_I),
		.rst_n_i(RESETN_I),
		.a_addr_i(mem_a_addr),
		.a_we_i(mem_a_we),
		.a_wdata_i(mem_a_wdata),
		.a_rdata_o(mem_a_rdata),
		.b_addr_i(mem_b_addr),
		.b_rdata_o(mem_b_rdata)
	);

	// Bus side of the size memory
	always_comb begin
		live_addr = {AVS_ADDRESS_I[3:2], 2'h0};
		if (s_r.st == otgsz_pkg::OTGSZ_S_IDLE) begin
			sel_addr = live_addr;
		end else begin
			sel_addr = s_r.addr_q;
		end
		sel_rx = (sel_addr == `OTGSZ_OFF_RXSZ);
		mem_a_addr = {sel_rx, s_r.ep_index};
		do_write = (s_r.st == otgsz_pkg::OTGSZ_S_ACK) && s_r.wr_q && s_r.be0_q;
		mem_a_we = do_write && ((s_r.addr_q == `OTGSZ_OFF_TXSZ) ||
			(s_r.addr_q == `OTGSZ_OFF_RXSZ));
		// Upper three bits never reach storage
		mem_a_wdata = s_r.wdata_q[`OTGSZ_SZ_W-1:0];
		wr_role = do_write && (s_r.addr_q == `OTGSZ_OFF_ROLE);
		mem_b_addr = {PKT_DIR_I, PKT_EP_I};
	end

	// Size arithmetic on the lookup entry
	always_comb begin
		max_shift = 5'(mem_b_rdata[`OTGSZ_EXP_HI:`OTGSZ_EXP_LO]) + `OTGSZ_BASE_SHIFT;
		fifo_shift = max_shift + 5'(mem_b_rdata[`OTGSZ_DPB_BIT]);
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.hnp_start = 1'b0;
		s_nxt.disconnect = 1'b0;
		s_nxt.pkt_done = 1'b0;
		s_nxt.host_flag = HOST_ROLE_I;
		s_nxt.suspend_d = SUSPEND_I;

		// Bus sequencer
		case (s_r.st)
			otgsz_pkg::OTGSZ_S_IDLE: begin
				s_nxt.waitreq = 1'b1;
				if (AVS_READ_I || AVS_WRITE_I) begin
					s_nxt.addr_q = live_addr;
					s_nxt.wr_q = AVS_WRITE_I;
					s_nxt.wdata_q = AVS_WRITEDATA_I[7:0];
					s_nxt.be0_q = AVS_BYTEENABLE_I[0];
					s_nxt.st = otgsz_pkg::OTGSZ_S_WAIT;
				end
			end
			otgsz_pkg::OTGSZ_S_WAIT: begin
				s_nxt.waitreq = 1'b0;
				s_nxt.readdata = 32'h0000_0000;
				case (s_r.addr_q)
					`OTGSZ_OFF_ROLE: begin
						s_nxt.readdata[`OTGSZ_SESSION_BIT] = s_r.session;
						s_nxt.readdata[`OTGSZ_SWAP_BIT] = s_r.swap_req;
						s_nxt.readdata[`OTGSZ_HOST_BIT] = s_r.host_flag;
						s_nxt.readdata[`OTGSZ_VBUS_HI:`OTGSZ_VBUS_LO] = vbus_code;
					end
					`OTGSZ_OFF_EPIDX: begin
						s_nxt.readdata[`OTGSZ_EP_W-1:0] = s_r.ep_index;
					end
					`OTGSZ_OFF_TXSZ, `OTGSZ_OFF_RXSZ: begin
						// Bits 7 to 5 stay zero
						s_nxt.readdata[`OTGSZ_SZ_W-1:0] = mem_a_rdata;
					end
					default: begin
						s_nxt.readdata = 32'h0000_0000;
					end
				endcase
				s_nxt.st = otgsz_pkg::OTGSZ_S_ACK;
			end
			otgsz_pkg::OTGSZ_S_ACK: begin
				// Write lands on the edge that sees waitrequest low
				s_nxt.waitreq = 1'b1;
				s_nxt.st = otgsz_pkg::OTGSZ_S_IDLE;
				if (do_write && (s_r.addr_q == `OTGSZ_OFF_EPIDX)) begin
					s_nxt.ep_index = s_r.wdata_q[`OTGSZ_EP_W-1:0];
				end
			end
			default: begin
				s_nxt.waitreq = 1'b1;
				s_nxt.st = otgsz_pkg::OTGSZ_S_IDLE;
			end
		endcase

		// Session bit: software write first, link events override
		if (wr_role) begin
			s_nxt.session = s_r.wdata_q[`OTGSZ_SESSION_BIT];
		end
		if (B_DEVICE_I) begin
			// Start wins if both events coincide
			if (SESSION_START_I) begin
				s_nxt.session = 1'b1;
			end else if (SESSION_END_I) begin
				s_nxt.session = 1'b0;
			end
		end
		// No disconnect when a session start overrides the clearing write
		if (wr_role && s_r.session && !s_r.wdata_q[`OTGSZ_SESSION_BIT] && !s_nxt.session &&
			SUSPEND_I) begin
			s_nxt.disconnect = 1'b1;
		end

		// Swap request: completion clears, a fresh software set wins
		if (HNP_DONE_I) begin
			s_nxt.swap_req = 1'b0;
		end
		if (wr_role) begin
			s_nxt.swap_req = s_r.wdata_q[`OTGSZ_SWAP_BIT];
		end
		if (SUSPEND_I && !s_r.suspend_d && s_r.swap_req && B_DEVICE_I) begin
			s_nxt.hnp_start = 1'b1;
		end

		// Packet size check, one stage behind the lookup read
		s_nxt.chk_v = PKT_CHK_I;
		if (PKT_CHK_I) begin
			s_nxt.chk_len = PKT_LEN_I;
		end
		if (s_r.chk_v) begin
			s_nxt.pkt_done = 1'b1;
			s_nxt.dbl = mem_b_rdata[`OTGSZ_DPB_BIT];
			s_nxt.max_pkt = `OTGSZ_BYTES_W'(1) << max_shift;
			s_nxt.fifo_bytes = `OTGSZ_BYTES_W'(1) << fifo_shift;
			s_nxt.too_big = s_r.chk_len > (`OTGSZ_BYTES_W'(1) << max_shift);
		end
	end

	// Lookup address is sampled live, so the result refers to the request cycle
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			s_r <= '0;
			s_r.st <= otgsz_pkg::OTGSZ_S_IDLE;
			s_r.waitreq <= 1'b1;
			s_r.session <= `OTGSZ_ROLE_RST;
			s_r.swap_req <= `OTGSZ_ROLE_RST;
			s_r.ep_index <= `OTGSZ_EPIDX_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign AVS_READDATA_O = s_r.readdata;
	assign AVS_WAITREQUEST_O = s_r.waitreq;
	assign SESSION_O = s_r.session;
	assign ROLE_SWAP_REQUEST_O = s_r.swap_req;
	assign HNP_START_O = s_r.hnp_start;
	assign DISCONNECT_O = s_r.disconnect;
	assign PKT_DONE_O = s_r.pkt_done;
	assign PKT_TOO_BIG_O = s_r.too_big;
	assign PKT_DOUBLE_O = s_r.dbl;
	assign PKT_MAX_BYTES_O = s_r.max_pkt;
	assign PKT_FIFO_BYTES_O = s_r.fifo_bytes;

endmodule : otgsz_top

// ==== hdl/otgsz_vbus_enc.sv ====
// Purpose: Encodes VBus comparator levels into the two-bit level code
// Assumes: Comparator levels synchronous to the clock
// Notes: Highest threshold passed wins
`timescale 1ns/1ps
`include "otgsz_defines.svh"

module otgsz_vbus_enc (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Comparators
	input wire logic above_sess_end_i,
	input wire logic above_avalid_i,
	input wire logic above_vbusvalid_i,
	// Code
	output logic [1:0] code_o
);

	otgsz_pkg::otgsz_vbus_t s_r;
	otgsz_pkg::otgsz_vbus_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (above_vbusvalid_i) begin
			s_nxt.code = `OTGSZ_VBUS_ABOVE_VV;
		end else if (above_avalid_i) begin
			s_nxt.code = `OTGSZ_VBUS_ABOVE_AV;
		end else if (above_sess_end_i) begin
			s_nxt.code = `OTGSZ_VBUS_ABOVE_SE;
		end else begin
			s_nxt.code = `OTGSZ_VBUS_BELOW_SE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign code_o = s_r.code;

endmodule : otgsz_vbus_enc

// ==== verification/otgsz_peer.sv ====
// Purpose: Cable partner answering host negotiation
// Assumes: Negotiation ends dly_i + 1 cycles after the edge that samples the start pulse
// Notes: Prompt at zero delay, slow otherwise
`timescale 1ns/1ps

module otgsz_peer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Negotiation
	input wire logic hnp_start_i,
	input wire logic [3:0] dly_i,
	output logic hnp_done_o
);
	logic [4:0] cnt_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 5'h00;
			hnp_done_o <= 1'b0;
		end else begin
			hnp_done_o <= (cnt_r == 5'h01);
			if (hnp_start_i)
				cnt_r <= {1'b0, dly_i} + 5'h01;
			else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
		end
	end
endmodule : otgsz_peer

// ==== verification/otgsz_top_properties.sv ====
// Purpose: Port checker of the role and sizing bank
// Assumes: One clock domain
// Notes: Bound to every top instance
`timescale 1ns/1ps
`include "otgsz_defines.svh"

module otgsz_top_chk (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Bus and link
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic B_DEVICE_I,
	input wire logic SUSPEND_I,
	input wire logic SESSION_START_I,
	input wire logic SESSION_O,
	input wire logic ROLE_SWAP_REQUEST_O,
	input wire logic HNP_START_O,
	input wire logic HNP_DONE_I,
	input wire logic DISCONNECT_O,
	// Packet check
	input wire logic PKT_CHK_I,
	input wire logic [`OTGSZ_BYTES_W-1:0] PKT_LEN_I,
	input wire logic PKT_DONE_O,
	input wire logic PKT_TOO_BIG_O,
	input wire logic PKT_DOUBLE_O,
	input wire logic [`OTGSZ_BYTES_W-1:0] PKT_MAX_BYTES_O,
	input wire logic [`OTGSZ_BYTES_W-1:0] PKT_FIFO_BYTES_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	wire wdone = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	property p_ans; $rose(AVS_READ_I || AVS_WRITE_I) |-> ##2 !AVS_WAITREQUEST_O; endproperty
	a_ans: assert property (p_ans) else $error("late bus answer");
	property p_one; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
	a_one: assert property (p_one) else $error("long answer");
	property p_hnp; B_DEVICE_I && ROLE_SWAP_REQUEST_O && $rose(SUSPEND_I) |=> HNP_START_O; endproperty
	a_hnp: assert property (p_hnp) else $error("no negotiation");
	property p_hpul; HNP_START_O |=> !HNP_START_O; endproperty
	a_hpul: assert property (p_hpul) else $error("long start");
	property p_swp; HNP_DONE_I && !wdone |=> !ROLE_SWAP_REQUEST_O; endproperty
	a_swp: assert property (p_swp) else $error("swap kept");
	property p_ses; B_DEVICE_I && SESSION_START_I |=> SESSION_O; endproperty
	a_ses: assert property (p_ses) else $error("session not set");
	property p_dis; DISCONNECT_O |-> $past(SUSPEND_I) && $past(SESSION_O) && !SESSION_O; endproperty
	a_dis: assert property (p_dis) else $error("bad disconnect");
	property p_pkt; PKT_CHK_I |-> ##2 PKT_DONE_O; endproperty
	a_pkt: assert property (p_pkt) else $error("late check");
	property p_fifo; PKT_DONE_O |-> PKT_FIFO_BYTES_O == (PKT_MAX_BYTES_O << PKT_DOUBLE_O); endproperty
	a_fifo: assert property (p_fifo) else $error("fifo bytes");
	property p_big; PKT_DONE_O |-> PKT_TOO_BIG_O == ($past(PKT_LEN_I, 2) > PKT_MAX_BYTES_O); endproperty
	a_big: assert property (p_big) else $error("size verdict");
	c_hnp: cover property (HNP_START_O);
	c_dis: cover property (DISCONNECT_O);
	c_big: cover property (PKT_DONE_O && PKT_TOO_BIG_O && PKT_DOUBLE_O);
endmodule : otgsz_top_chk

bind otgsz_top otgsz_top_chk otgsz_top_chk_i (.*);

// ==== verification/otgsz_top_tb.sv ====
// Purpose: Self-checking bench of the role and sizing bank
// Assumes: Three-cycle bus answer, two-cycle packet check
// Notes: Peer model answers negotiation
`timescale 1ns/1ps
`include "otgsz_defines.svh"

module otgsz_top_tb;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, ase = 0, aav = 0, avv = 0, bdev = 0, host = 0;
	logic susp = 0, sst = 0, sen = 0, chk = 0, dir = 0, sess, swap, hst, disc, done, big, dbl;
	logic hdone, waitreq;
	logic [3:0] adr = 0, be = 4'hF, ep = 0, dly = 0;
	logic [31:0] wd = 0, rdata, q;
	logic [`OTGSZ_BYTES_W-1:0] len = 0, maxb, fifob;
	int n_fail = 0, checked = 0;
	always #4 clk = ~clk;
	otgsz_top otgsz_top_i (.CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .ABOVE_SESS_END_I(ase),
		.ABOVE_AVALID_I(aav), .ABOVE_VBUSVALID_I(avv), .B_DEVICE_I(bdev), .HOST_ROLE_I(host),
		.SUSPEND_I(susp), .HNP_DONE_I(hdone), .SESSION_START_I(sst), .SESSION_END_I(sen),
		.SESSION_O(sess), .ROLE_SWAP_REQUEST_O(swap), .HNP_START_O(hst), .DISCONNECT_O(disc),
		.PKT_CHK_I(chk), .PKT_DIR_I(dir), .PKT_EP_I(ep), .PKT_LEN_I(len), .PKT_DONE_O(done),
		.PKT_TOO_BIG_O(big), .PKT_DOUBLE_O(dbl), .PKT_MAX_BYTES_O(maxb),
		.PKT_FIFO_BYTES_O(fifob));
	otgsz_peer otgsz_peer_i (.clk_i(clk), .rst_n_i(rst_n), .hnp_start_i(hst), .dly_i(dly),
		.hnp_done_o(hdone));

	task print_verdict;
		$display("Checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task cmp(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : cmp
	// Bounded waits end the run rather than hang it
	task bus(logic w, logic [3:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
			if (i > 20) begin
				n_fail++;
				print_verdict;
			end
		end while (waitreq !== 1'b0);
		q = rdata;
		rd <= 0;
		wr <= 0;
	endtask : bus
	task rchk(logic [3:0] a, logic [31:0] e);
		bus(0, a, 0);
		cmp("reg", q, e);
	endtask : rchk
	task pulse(logic s);
		@(posedge clk);
		if (s) sst <= 1; else sen <= 1;
		@(posedge clk);
		sst <= 0;
		sen <= 0;
		@(negedge clk);
	endtask : pulse
	task pkt(logic d, logic [`OTGSZ_BYTES_W-1:0] l);
		int i;
		@(posedge clk);
		chk <= 1;
		dir <= d;
		len <= l;
		@(posedge clk);
		chk <= 0;
		for (i = 0; i < 5 && done !== 1'b1; i++) @(negedge clk);
		if (i == 5) begin
			n_fail++;
			print_verdict;
		end
	endtask : pkt

	task t_reset;
		for (int a = 0; a < 16; a += 4) rchk(a, 0);
	endtask : t_reset
	task t_vbus;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			ase <= k > 0;
			aav <= k > 1;
			avv <= k > 2;
			host <= k[0];
			rchk(0, (k << 3) | ((k & 1) << 2));
		end
		{ase, aav, avv, host} <= 0;
	endtask : t_vbus
	task t_size;
		bus(1, 4, 5);
		bus(1, 8, 'hFF);
		bus(1, 'hC, 'h0A);
		rchk(8, 'h1F);
		rchk('hC, 'h0A);
		bus(1, 4, 6);
		rchk(8, 0);
		be <= 0;
		bus(1, 8, 'h1F);
		be <= 'hF;
		rchk(8, 0);
	endtask : t_size
	task t_pkt;
		ep <= 6;
		for (int m = 0; m < 16; m++) for (int d = 0; d < 2; d++) begin
			bus(1, 8 + 4 * m[0], {d[0], m[3:0]});
			pkt(m[0], (1 << (m + 3)) + d);
			cmp("max", maxb, 1 << (m + 3));
			cmp("fifo", fifob, 1 << (m + 3 + d));
			cmp("dbl", dbl, d);
			cmp("big", big, d);
		end
	endtask : t_pkt
	task t_hnp;
		for (int n = 0; n < 3; n++) begin
			@(posedge clk);
			bdev <= n < 2;
			dly <= 4 * n;
			bus(1, 0, 2);
			@(posedge clk);
			susp <= 1;
			repeat (2) @(negedge clk);
			cmp("start", hst, n < 2);
			repeat (3) @(negedge clk);
			// Prompt peer has finished by now, slow peer not yet; A role never starts one and keeps the request
			cmp("swap", swap, n != 0);
			repeat (8) @(negedge clk);
			rchk(0, (n == 2) << 1);
			susp <= 0;
		end
		bus(1, 0, 0);
	endtask : t_hnp
	task t_sess;
		bdev <= 0;
		bus(1, 0, 1);
		rchk(0, 1);
		pulse(0);
		cmp("sess", sess, 1);
		@(posedge clk);
		bdev <= 1;
		pulse(0);
		cmp("sess", sess, 0);
		bus(1, 0, 1);
		@(negedge clk);
		cmp("srp", sess, 1);
		pulse(0);
		cmp("sess", sess, 0);
		pulse(1);
		cmp("sess", sess, 1);
		@(posedge clk);
		susp <= 1;
		bus(1, 0, 0);
		@(negedge clk);
		cmp("disc", disc, 1);
		@(posedge clk);
		susp <= 0;
	endtask : t_sess

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_vbus;
		t_size;
		t_pkt;
		t_hnp;
		t_sess;
		print_verdict;
	end
endmodule : otgsz_top_tb
